// ---- src/reactive_energy_accumulator.sv ----
// Purpose: reactive power offset, sign, no-load and energy accumulation
// Assumes: filtered, gain-corrected channel power arrives synchronous
// Notes: registers over APB, one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
`include "reactive_energy_cfg.svh"

// Notes on behaviour
// - two signed 16-bit offsets, one added per channel's filtered power
// - offset value 128 equals one filter output LSB
// - filter full scale is 0x200000, the no-load reference
// - power sign follows phase; positive 0 to +90, negative -90 to 0
// - edge select 0 fires positive-to-negative, 1 negative-to-positive
// - sign-change flag sticky until software writes zero to it
// - unmasked sign-change flag drives the sign-change interrupt
// - threshold code 00 off, 01 0.015%, 10 0.0075%, 11 0.0037%
// - power below enabled threshold is not accumulated
// - no-load flag set below threshold; unmasked it holds an interrupt
// - 42-bit signed accumulator, upper 24 bits visible
// - accumulator updated once every 230.4 us sample period
// - mode 00 signed, 01 and 11 absolute, 10 positive only
// - power divided by an 8-bit unsigned divider before accumulation
// - divider zero behaves as divider one
// - plain readout returns upper 24 bits, accumulator untouched
// - read-and-clear returns upper 24 bits then clears them
// - line-cycle readout captures energy synchronised to line cycles
// - overflow wraps to 0x800000 upward; underflow to maximum positive
// - half-full and overflow flags, each interrupting when unmasked
// - overflow time scales linearly with the divider value
// - signed mode adds positive, subtracts negative; default after reset
// - absolute mode accumulates magnitude, skipping no-load samples
// - half-cycle count write resets line readout; restart at crossing
module reactive_energy_accumulator
	import reactive_energy_pkg::*;
#(
	parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_resetn,
	// apb slave
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [11:0]           i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic                       o_pready,
	output logic [31:0]                o_prdata,
	output logic                       o_pslverr,
	// filtered reactive power
	input  wire logic [`POWER_W-1:0]   i_react_ch1,
	input  wire logic [`POWER_W-1:0]   i_react_ch2,
	input  wire logic                  i_zero_cross,
	// interrupt requests
	output logic                       o_sign_change_irq,
	output logic                       o_noload_irq,
	output logic                       o_half_full_irq,
	output logic                       o_overflow_irq,
	output logic                       o_cycle_end_irq
);

	localparam int SW = $clog2(SAMPLE_CYCLES);

	// software registers
	logic [`OFFSET_W-1:0]  reactive_offset_ch1;
	logic [`OFFSET_W-1:0]  reactive_offset_ch2;
	logic [7:0]            reactive_energy_divider;
	control_type           control;
	logic [15:0]           half_cycle_count_reg;
	flag_type              flags;
	flag_type              mask;

	// datapath state
	logic [SW-1:0]         sample_count;
	logic [`ACC_W-1:0]     acc;
	logic [`ACC_W-1:0]     line_acc;
	logic [`VISIBLE_W-1:0] line_cycle_reactive_energy;
	logic [15:0]           line_count;
	line_state_type        line_state;
	logic                  prev_neg;
	logic                  prev_valid;

	// sample period divider
	wire sample_tick = (sample_count == SW'(SAMPLE_CYCLES - 1));

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sample_count <= '0;
		end else if (sample_tick) begin
			sample_count <= '0;
		end else begin
			sample_count <= sample_count + SW'(1);
		end
	end

	// apb decode
	wire apb_access  = i_psel & i_penable;
	wire apb_done    = apb_access & o_pready;
	wire apb_capture = apb_access & ~o_pready;
	wire wr          = apb_done & i_pwrite;
	wire rd_capture  = apb_capture & ~i_pwrite;

	wire sel_off1   = (i_paddr == `ADDR_OFFSET_CH1);
	wire sel_off2   = (i_paddr == `ADDR_OFFSET_CH2);
	wire sel_div    = (i_paddr == `ADDR_DIVIDER);
	wire sel_ctrl   = (i_paddr == `ADDR_CONTROL);
	wire sel_cycles = (i_paddr == `ADDR_HALF_CYCLES);
	wire sel_status = (i_paddr == `ADDR_STATUS);
	wire sel_mask   = (i_paddr == `ADDR_MASK);
	wire sel_read   = (i_paddr == `ADDR_READOUT);
	wire sel_rc     = (i_paddr == `ADDR_READ_CLEAR);
	wire sel_line   = (i_paddr == `ADDR_LINE_READOUT);
	wire sel_hit    = sel_off1 | sel_off2 | sel_div | sel_ctrl |
		sel_cycles | sel_status | sel_mask | sel_read | sel_rc |
		sel_line;

	wire read_clear = rd_capture & sel_rc;
	wire line_write = wr & sel_cycles;

	wire [`VISIBLE_W-1:0] visible = acc[`ACC_W-1:`VISIBLE_LSB];

	wire [31:0] read_mux =
		sel_off1   ? {16'h0000, reactive_offset_ch1} :
		sel_off2   ? {16'h0000, reactive_offset_ch2} :
		sel_div    ? {24'h000000, reactive_energy_divider} :
		sel_ctrl   ? {25'h0000000, control} :
		sel_cycles ? {16'h0000, half_cycle_count_reg} :
		sel_status ? {27'h0000000, flags} :
		sel_mask   ? {27'h0000000, mask} :
		sel_line   ? {8'h00, line_cycle_reactive_energy} :
		(sel_read | sel_rc) ? {8'h00, visible} :
		32'h00000000;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= apb_capture;
			o_prdata  <= rd_capture ? read_mux : 32'h00000000;
			o_pslverr <= apb_capture & ~sel_hit;
		end
	end

	// register writes
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			reactive_offset_ch1     <= '0;
			reactive_offset_ch2     <= '0;
			reactive_energy_divider <= `DIVIDER_RESET;
			control                 <= `CONTROL_RESET;
			half_cycle_count_reg    <= 16'h0000;
			mask                    <= `MASK_RESET;
		end else if (wr) begin
			if (sel_off1)
				reactive_offset_ch1 <= i_pwdata[`OFFSET_W-1:0];
			if (sel_off2)
				reactive_offset_ch2 <= i_pwdata[`OFFSET_W-1:0];
			if (sel_div)
				reactive_energy_divider <= i_pwdata[7:0];
			if (sel_ctrl)
				control <= control_type'(i_pwdata[`CONTROL_W-1:0]);
			if (sel_cycles)
				half_cycle_count_reg <= i_pwdata[15:0];
			if (sel_mask)
				mask <= flag_type'(i_pwdata[`FLAG_W-1:0]);
		end
	end

	// offset correction, 7 fraction bits
	wire [`CORR_W-1:0] corr1 =
		{i_react_ch1[`POWER_W-1], i_react_ch1, 7'h00} +
		{{16{reactive_offset_ch1[15]}}, reactive_offset_ch1};
	wire [`CORR_W-1:0] corr2 =
		{i_react_ch2[`POWER_W-1], i_react_ch2, 7'h00} +
		{{16{reactive_offset_ch2[15]}}, reactive_offset_ch2};
	wire [`CORR_W:0] corr_sum =
		{corr1[`CORR_W-1], corr1} + {corr2[`CORR_W-1], corr2};
	wire [`CORR_W-1:0] power =
		control.three_wire ? corr_sum[`CORR_W:1] : corr1;

	// sign and magnitude
	wire               power_neg = power[`CORR_W-1];
	wire [`CORR_W-1:0] power_mag = power_neg ? (~power + 32'h1) : power;

	// no-load threshold relative to full scale
	wire [11:0] noload_level =
		(control.noload_threshold == 2'b01) ? `NOLOAD_T01 :
		(control.noload_threshold == 2'b10) ? `NOLOAD_T10 :
		(control.noload_threshold == 2'b11) ? `NOLOAD_T11 :
		12'h000;
	wire noload_on = (control.noload_threshold != 2'b00);
	wire below     = noload_on &
		(power_mag < {13'h0000, noload_level, 7'h00});

	// energy divider
	wire [7:0] div_eff = (reactive_energy_divider == 8'h00) ?
		8'h01 : reactive_energy_divider;
	wire [`CORR_W-1:0] quotient =
		power_mag / {24'h000000, div_eff};
	wire [`ACC_W-1:0] qext = {17'h00000, quotient};

	// accumulation mode selection
	logic [`ACC_W-1:0] delta;

	always_comb begin
		delta = '0;
		unique case (control.accum_mode)
			MODE_SIGNED: begin
				delta = power_neg ? (~qext + 49'h1) : qext;
			end
			MODE_ABS, MODE_ABS_ALT: begin
				delta = qext;
			end
			MODE_POSITIVE: begin
				delta = power_neg ? '0 : qext;
			end
		endcase
		if (below)
			delta = '0;
	end

	// main accumulator
	wire [`ACC_W-1:0] acc_base = read_clear ?
		{24'h000000, acc[`VISIBLE_LSB-1:0]} : acc;
	wire [`ACC_W-1:0] acc_sum = acc_base + delta;
	wire acc_over = sample_tick &
		(acc_base[`ACC_W-1] == delta[`ACC_W-1]) &
		(acc_sum[`ACC_W-1] != acc_base[`ACC_W-1]);
	wire half_before = acc_base[`ACC_W-1] ^ acc_base[`ACC_W-2];
	wire half_after  = acc_sum[`ACC_W-1] ^ acc_sum[`ACC_W-2];
	wire half_event  = sample_tick & ~acc_over & ~half_before &
		half_after;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc <= '0;
		end else if (sample_tick) begin
			acc <= acc_sum;
		end else if (read_clear) begin
			acc <= acc_base;
		end
	end

	// sign-change detection
	wire sign_event = sample_tick & prev_valid &
		(control.sign_edge_select ? (prev_neg & ~power_neg) :
		(~prev_neg & power_neg));

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prev_neg   <= 1'b0;
			prev_valid <= 1'b0;
		end else if (sample_tick) begin
			prev_neg   <= power_neg;
			prev_valid <= 1'b1;
		end
	end

	// line-cycle accumulation
	wire [`ACC_W-1:0] line_next = line_acc +
		(sample_tick ? delta : '0);
	wire [15:0] count_next = line_count + 16'h0001;
	wire cycle_done = (line_state == LINE_RUN) & i_zero_cross &
		~control.cycle_disable &
		(count_next == half_cycle_count_reg);
	wire line_reset = line_write & ~control.cycle_disable;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			line_state                 <= LINE_IDLE;
			line_acc                   <= '0;
			line_count                 <= 16'h0000;
			line_cycle_reactive_energy <= '0;
		end else if (line_reset) begin
			line_state                 <= LINE_WAIT;
			line_acc                   <= '0;
			line_count                 <= 16'h0000;
			line_cycle_reactive_energy <= '0;
		end else begin
			unique case (line_state)
				LINE_IDLE: begin
					line_acc <= '0;
				end
				LINE_WAIT: begin
					if (i_zero_cross)
						line_state <= LINE_RUN;
				end
				LINE_RUN: begin
					if (cycle_done) begin
						line_cycle_reactive_energy <=
							line_next[`ACC_W-1:`VISIBLE_LSB];
						line_acc   <= '0;
						line_count <= 16'h0000;
					end else begin
						line_acc <= line_next;
						if (i_zero_cross)
							line_count <= count_next;
					end
				end
				default: begin
					line_state <= LINE_IDLE;
				end
			endcase
		end
	end

	// sticky flags, written zero clears, a set wins
	flag_type events;
	flag_type keep;
	flag_type next_flags;

	assign events = '{
		cycle_end:   cycle_done,
		overflow:    acc_over,
		half_full:   half_event,
		noload:      sample_tick & below,
		sign_change: sign_event
	};
	assign keep = (wr & sel_status) ?
		flag_type'(i_pwdata[`FLAG_W-1:0]) : flag_type'(`MASK_RESET);
	assign next_flags = (flags & keep) | events;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

	// interrupt requests from unmasked flags
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sign_change_irq <= 1'b0;
			o_noload_irq      <= 1'b0;
			o_half_full_irq   <= 1'b0;
			o_overflow_irq    <= 1'b0;
			o_cycle_end_irq   <= 1'b0;
		end else begin
			o_sign_change_irq <= next_flags.sign_change &
				~mask.sign_change;
			o_noload_irq      <= next_flags.noload &
				~mask.noload;
			o_half_full_irq   <= next_flags.half_full &
				~mask.half_full;
			o_overflow_irq    <= next_flags.overflow &
				~mask.overflow;
			o_cycle_end_irq   <= next_flags.cycle_end &
				~mask.cycle_end;
		end
	end

endmodule
`default_nettype wire

// ---- src/reactive_energy_cfg.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: definitions only
`ifndef REACTIVE_ENERGY_CFG_SVH
`define REACTIVE_ENERGY_CFG_SVH

// register byte addresses
`define ADDR_OFFSET_CH1     12'h000
`define ADDR_OFFSET_CH2     12'h004
`define ADDR_DIVIDER        12'h008
`define ADDR_CONTROL        12'h00c
`define ADDR_HALF_CYCLES    12'h010
`define ADDR_STATUS         12'h014
`define ADDR_MASK           12'h018
`define ADDR_READOUT        12'h01c
`define ADDR_READ_CLEAR     12'h020
`define ADDR_LINE_READOUT   12'h024

// widths and field positions
`define POWER_W             24
`define OFFSET_W            16
`define OFFSET_FRAC         7
`define CORR_W              32
`define ACC_INT_W           42
`define ACC_W               49
`define VISIBLE_W           24
`define VISIBLE_LSB         25
`define CONTROL_W           7
`define FLAG_W              5

// reset values
`define DIVIDER_RESET       8'h01
`define CONTROL_RESET       7'h00
`define MASK_RESET          5'h1f

// full scale 0x200000; thresholds 0.015%, 0.0075%, 0.0037% of it
`define FULL_SCALE          24'h200000
`define NOLOAD_T01          12'h13a
`define NOLOAD_T10          12'h09d
`define NOLOAD_T11          12'h04d

// accumulation period
`define CLK_PERIOD_PS       4000
`define SAMPLE_PERIOD_PS    230400000
`define SAMPLE_CYCLES       (`SAMPLE_PERIOD_PS / `CLK_PERIOD_PS)

`endif

// ---- src/reactive_energy_pkg.sv ----
// Purpose: types shared by the reactive energy block
// Assumes: constants come from reactive_energy_cfg.svh
// Notes: none
`include "reactive_energy_cfg.svh"

package reactive_energy_pkg;

	typedef enum logic [1:0] {
		MODE_SIGNED   = 2'b00,
		MODE_ABS      = 2'b01,
		MODE_POSITIVE = 2'b10,
		MODE_ABS_ALT  = 2'b11
	} accum_mode_type;

	typedef struct packed {
		logic           cycle_disable;
		logic           three_wire;
		logic [1:0]     noload_threshold;
		logic           sign_edge_select;
		accum_mode_type accum_mode;
	} control_type;

	typedef struct packed {
		logic cycle_end;
		logic overflow;
		logic half_full;
		logic noload;
		logic sign_change;
	} flag_type;

	typedef enum logic [2:0] {
		LINE_IDLE = 3'b001,
		LINE_WAIT = 3'b010,
		LINE_RUN  = 3'b100
	} line_state_type;

endpackage

// ---- tb/reactive_energy_properties.sv ----
// Purpose: port checks for the reactive energy block
// Assumes: apb master holds each request until ready
// Notes: bound to the design top
`timescale 1ns/1ps
`default_nettype none
`include "reactive_energy_cfg.svh"
module reactive_energy_properties
	import reactive_energy_pkg::*;
#(
	parameter int SAMPLE_CYCLES = 16
) (
	// clock and reset
	input wire logic                i_clk,
	input wire logic                i_resetn,
	// apb
	input wire logic                i_psel,
	input wire logic                i_penable,
	input wire logic                i_pwrite,
	input wire logic [11:0]         i_paddr,
	input wire logic [31:0]         i_pwdata,
	input wire logic                o_pready,
	input wire logic [31:0]         o_prdata,
	input wire logic                o_pslverr,
	// power
	input wire logic [`POWER_W-1:0] i_react_ch1,
	input wire logic [`POWER_W-1:0] i_react_ch2,
	input wire logic                i_zero_cross,
	// interrupts
	input wire logic                o_sign_change_irq,
	input wire logic                o_noload_irq,
	input wire logic                o_half_full_irq,
	input wire logic                o_overflow_irq,
	input wire logic                o_cycle_end_irq
);
	logic wr_done;
	logic seen_wr;
	assign wr_done = i_psel & i_penable & o_pready & i_pwrite;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn)
			seen_wr <= 1'b0;
		else if (wr_done)
			seen_wr <= 1'b1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence setup_s;
		i_psel && !i_penable;
	endsequence
	sequence one_wait_s;
		!o_pready ##1 o_pready;
	endsequence
	property held_p(irq);
		irq && !wr_done && !$past(wr_done) |=> irq;
	endproperty
	chk_apb_wait: assert property (setup_s |=> one_wait_s)
		else $error("apb answer not after one wait");
	chk_ready_pulse: assert property (o_pready |=> !o_pready)
		else $error("ready held two cycles");
	chk_idle_data: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	chk_err_decode: assert property (o_pready &&
		i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 12'h024))
		else $error("error flag wrong for address");
	chk_read_narrow: assert property (o_pready && !i_pwrite &&
		i_paddr >= 12'h01c |-> o_prdata[31:24] == 8'h0)
		else $error("readout wider than 24 bits");
	chk_offset_narrow: assert property (o_pready && !i_pwrite &&
		i_paddr <= 12'h004 |-> o_prdata[31:16] == 16'h0)
		else $error("offset wider than 16 bits");
	chk_sign_sticky: assert property (held_p(o_sign_change_irq))
		else $error("sign irq fell without a write");
	chk_noload_held: assert property (held_p(o_noload_irq))
		else $error("no-load irq fell without a write");
	chk_ovf_held: assert property (held_p(o_overflow_irq))
		else $error("overflow irq fell without a write");
	chk_cycle_held: assert property (held_p(o_cycle_end_irq))
		else $error("cycle-end irq fell without a write");
	chk_masked_quiet: assert property (!seen_wr |->
		{o_cycle_end_irq, o_overflow_irq, o_half_full_irq,
		o_noload_irq, o_sign_change_irq} == 5'h0)
		else $error("irq before any mask write");
endmodule
bind reactive_energy_accumulator reactive_energy_properties #(
	.SAMPLE_CYCLES(SAMPLE_CYCLES)
) i_props (
	.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
	.o_pslverr(o_pslverr), .i_react_ch1(i_react_ch1),
	.i_react_ch2(i_react_ch2), .i_zero_cross(i_zero_cross),
	.o_sign_change_irq(o_sign_change_irq), .o_noload_irq(o_noload_irq),
	.o_half_full_irq(o_half_full_irq), .o_overflow_irq(o_overflow_irq),
	.o_cycle_end_irq(o_cycle_end_irq)
);
`default_nettype wire

// ---- tb/power_source.sv ----
// Purpose: upstream filtered power source
// Assumes: tick every SAMPLE_CYCLES clocks after reset release
// Notes: holds a value for a counted number of ticks
`timescale 1ns/1ps
`default_nettype none
module power_source #(
	parameter int SAMPLE_CYCLES = 16
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// commands
	input  wire logic        i_load,
	input  wire logic [23:0] i_value,
	input  wire logic [23:0] i_rest,
	input  wire logic [3:0]  i_ticks,
	// power side
	output logic [23:0]      o_ch1,
	output logic [23:0]      o_ch2,
	output logic             o_zero_cross,
	output logic             o_busy
);
	int          phase;
	logic        pend;
	logic [3:0]  left;
	logic [23:0] hold;
	logic        tick;
	assign tick = phase == SAMPLE_CYCLES - 1;
	assign o_busy = pend | (left != 4'h0);
	// second channel carries half the first, for three-wire checks
	assign o_ch2 = {o_ch1[23], o_ch1[23:1]};
	assign o_zero_cross = phase == SAMPLE_CYCLES / 2;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase <= 0;
			pend <= 1'b0;
			left <= 4'h0;
			hold <= 24'h0;
			o_ch1 <= 24'h0;
		end else begin
			phase <= tick ? 0 : phase + 1;
			if (i_load) begin
				pend <= 1'b1;
				hold <= i_value;
			end
			// change only just after a tick edge
			if (tick && pend) begin
				pend <= 1'b0;
				left <= i_ticks;
				o_ch1 <= hold;
			end else if (tick && left != 4'h0) begin
				left <= left - 4'h1;
				if (left == 4'h1)
					o_ch1 <= i_rest;
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the reactive energy block
// Assumes: sample tick every 16 clocks
// Notes: scenarios run in order
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import reactive_energy_pkg::*;
();
	localparam int SC = 16;
	localparam logic [11:0] DV = 12'h008, CT = 12'h00c, ST = 12'h014;
	localparam logic [11:0] MK = 12'h018, RO = 12'h01c, RC = 12'h020;
	localparam logic [23:0] FS = 24'h200000, NFS = 24'he00000;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [23:0] ch1, ch2, val, rest;
	logic [3:0]  ticks;
	logic        zc, ld, busy;
	wire  [4:0]  irq;
	int          n_mismatch, check_count;
	reactive_energy_accumulator #(.SAMPLE_CYCLES(SC)) i_dut (
		.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_react_ch1(ch1), .i_react_ch2(ch2),
		.i_zero_cross(zc), .o_sign_change_irq(irq[0]),
		.o_noload_irq(irq[1]), .o_half_full_irq(irq[2]),
		.o_overflow_irq(irq[3]), .o_cycle_end_irq(irq[4])
	);
	power_source #(.SAMPLE_CYCLES(SC)) i_src (
		.i_clk(clk), .i_resetn(resetn), .i_load(ld), .i_value(val),
		.i_rest(rest), .i_ticks(ticks), .o_ch1(ch1), .o_ch2(ch2),
		.o_zero_cross(zc), .o_busy(busy)
	);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(q, x)
		`CHK(e, a > 12'h024)
	endtask
	task automatic feed(input logic [23:0] v, input logic [3:0] n);
		val <= v;
		ticks <= n;
		ld <= 1'b1;
		@(posedge clk);
		ld <= 1'b0;
		repeat (200) begin
			@(posedge clk);
			if (busy === 1'b0)
				break;
		end
	endtask
	task automatic t_reset();
		logic [31:0] rv [11] = '{0, 0, 1, 0, 0, 0, 'h1f, 0, 0, 0, 0};
		for (int i = 0; i < 11; i++)
			rdchk(12'(4 * i), rv[i]);
		$display("test reset done");
	endtask
	task automatic t_read();
		feed(FS, 3);
		rdchk(RO, 32'h18);
		rdchk(RO, 32'h18);
		feed(NFS, 1);
		rdchk(RC, 32'h10);
		rdchk(RO, 32'h0);
		$display("test readout done");
	endtask
	task automatic t_offset();
		wr(12'h000, 32'h0080);
		feed(24'h1fffff, 1);
		rdchk(RC, 32'h8);
		wr(12'h000, 32'hff80);
		feed(FS, 1);
		rdchk(RC, 32'h7);
		rdchk(12'h000, 32'hff80);
		wr(12'h000, 32'h0);
		wr(12'h004, 32'h1234);
		rdchk(12'h004, 32'h1234);
		$display("test offset done");
	endtask
	task automatic t_modes();
		logic [31:0] ex [4] = '{'hfffff0, 'h10, 'h0, 'h10};
		for (int m = 0; m < 4; m++) begin
			wr(CT, 32'(m));
			feed(NFS, 2);
			rdchk(RC, ex[m]);
		end
		$display("test modes done");
	endtask
	task automatic t_div();
		logic [7:0] d [5] = '{0, 1, 2, 4, 8};
		wr(CT, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(DV, {24'h0, d[i]});
			feed(FS, 2);
			rdchk(RC, 32'(16 / (d[i] == 0 ? 1 : d[i])));
		end
		wr(DV, 32'h1);
		$display("test divider done");
	endtask
	task automatic t_sign();
		for (int s = 0; s < 2; s++) begin
			wr(CT, 32'(s << 2));
			feed(FS, 1);
			wr(ST, 32'h0);
			feed(NFS, 1);
			rdchk(ST, 32'(s == 0));
			feed(FS, 1);
			rdchk(ST, 32'h1);
		end
		wr(MK, 32'h1e);
		repeat (2) @(posedge clk);
		`CHK(irq, 5'h01)
		wr(ST, 32'h0);
		repeat (2) @(posedge clk);
		`CHK(irq, 5'h00)
		wr(MK, 32'h1f);
		$display("test sign done");
	endtask
	task automatic t_noload();
		int th [4] = '{1, 314, 157, 77};
		rest <= FS;
		feed(FS, 1);
		for (int c = 0; c < 4; c++) begin
			wr(CT, 32'(c << 3));
			wr(ST, 32'h0);
			feed(24'(th[c]), 1);
			rdchk(ST, 32'h0);
			feed(24'(th[c] - 1), 1);
			rdchk(ST, c != 0 ? 32'h2 : 32'h0);
		end
		wr(MK, 32'h1d);
		repeat (20) @(posedge clk);
		`CHK(irq, 5'h02)
		wr(ST, 32'h0);
		repeat (2) @(posedge clk);
		`CHK(irq, 5'h00)
		$display("test no-load done");
	endtask
	task automatic t_line();
		wr(CT, 32'h0);
		wr(12'h010, 32'h2);
		repeat (80) @(posedge clk);
		rdchk(12'h024, 32'h10);
		rdchk(ST, 32'h10);
		wr(MK, 32'h0f);
		repeat (2) @(posedge clk);
		`CHK(irq, 5'h10)
		wr(CT, 32'h40);
		wr(ST, 32'h0);
		wr(12'h010, 32'h2);
		repeat (80) @(posedge clk);
		rdchk(12'h024, 32'h10);
		rdchk(ST, 32'h0);
		wr(CT, 32'h20);
		wr(12'h010, 32'h2);
		repeat (80) @(posedge clk);
		rdchk(12'h024, 32'h0c);
		wr(MK, 32'h1f);
		$display("test line cycle done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		n_mismatch = 0;
		check_count = 0;
		resetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ld, val, rest, ticks} = '0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_read();
		t_offset();
		t_modes();
		t_div();
		t_sign();
		t_noload();
		t_line();
		print_verdict();
	end
	// tests need under 2000 clocks; allow fifteen times that
	initial begin
		#120000;
		n_mismatch++;
		print_verdict();
	end
endmodule
`default_nettype wire
